//--- answer_watchdog_pkg.sv
/*
 * Constants shared by the answer watchdog status logic.
 * Assumes a single 100 MHz core clock and a plain register port.
 */
package answer_watchdog_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_COUNT = 4'h3;
	localparam logic [3:0] ADDR_ACTIVE = 4'h4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_INVALID = 0;
	localparam int BIT_TIMEOUT = 1;
	localparam int BIT_LIMIT = 2;
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_SEL_W = 2;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [2:0] ERROR_LIMIT = 3'h4;

	// ----------------------------------------------------------------
	// Timeout selection, nominal times in microseconds
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int TIMEOUT0_US = 1000;
	localparam int TIMEOUT1_US = 2000;
	localparam int TIMEOUT2_US = 4000;
	localparam int TIMEOUT3_US = 8000;
	localparam int TIMEOUT0_CYC = TIMEOUT0_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Sequence states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b11
	} seq_state_t;

endpackage : answer_watchdog_pkg

//--- answer_watchdog_status.sv
/*
 * Answer watchdog status: sequence timer, error flags, error counter,
 * interrupt and register port. Assumes answer checking is done outside;
 * it reports each answer as a valid or invalid pulse.
 */
// How it works
// - An invalid answer in a sequence sets a sticky flag cleared only by its clear bit.
// - A sequence with no answer before the timeout sets a sticky flag cleared by its clear bit.
// - When the error counter reaches 4 a sticky flag is set until its clear bit is written.
// - The limit clear bit clears only that flag and leaves the sequence counter alone.
// - Configuration is captured at the start command and used for the whole sequence.
`timescale 1ns/1ps
`default_nettype none
module answer_watchdog_status
	import answer_watchdog_pkg::*;
#(
	parameter int SEQ_W = 8,
	parameter int TIMEOUT_CYC = TIMEOUT0_CYC
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Watchdog events
	input wire logic start_cmd_i,
	input wire logic answer_valid_i,
	input wire logic answer_bad_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// Status outputs
	output logic answer_invalid_flag_o,
	output logic answer_timeout_flag_o,
	output logic error_limit_flag_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [26:0] timeout_for(input logic [1:0] sel);
		logic [26:0] base;
		base = 27'(TIMEOUT_CYC);
		timeout_for = base << sel;
	endfunction : timeout_for

	function automatic logic wr_hit(input logic [3:0] a);
		wr_hit = reg_write_i && (reg_addr_i == a);
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0] config_reg;
	logic [7:0] active_config;
	logic [2:0] mask;
	logic [2:0] error_count;
	logic [SEQ_W-1:0] seq_counter;
	logic [26:0] timer;
	seq_state_t state;
	logic seq_bad;
	logic seq_timeout;
	logic seq_fail;
	logic answer_invalid_clear;
	logic answer_timeout_clear;
	logic error_count_limit_clear;
	logic flag_inv;
	logic flag_to;
	logic flag_lim;
	logic limit_hit;
	logic [2:0] status;

	assign answer_invalid_clear = wr_hit(ADDR_STATUS) && reg_wdata_i[BIT_INVALID];
	assign answer_timeout_clear = wr_hit(ADDR_STATUS) && reg_wdata_i[BIT_TIMEOUT];
	assign error_count_limit_clear = wr_hit(ADDR_STATUS) && reg_wdata_i[BIT_LIMIT];

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			config_reg <= CONFIG_RESET;
		else if (clk_en_i && wr_hit(ADDR_CONFIG))
			config_reg <= reg_wdata_i;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			mask <= MASK_RESET;
		else if (clk_en_i && wr_hit(ADDR_MASK))
			mask <= reg_wdata_i[2:0];
	end

	// ----------------------------------------------------------------
	// Sequence timer
	// ----------------------------------------------------------------
	// A bad answer or a timeout ends the sequence with one failure
	assign seq_bad = (state == ST_WAIT) && answer_bad_i;
	assign seq_timeout = (state == ST_WAIT) && !answer_bad_i && !answer_valid_i
		&& (timer == 27'h0000001);
	assign seq_fail = seq_bad || seq_timeout;

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= ST_IDLE;
			timer <= 27'h0000000;
			active_config <= CONFIG_RESET;
			seq_counter <= '0;
		end
		else if (clk_en_i)
		begin
			if (start_cmd_i)
			begin
				active_config <= config_reg;
				timer <= timeout_for(config_reg[CFG_SEL_LSB +: CFG_SEL_W]);
				state <= ST_WAIT;
			end
			else
			begin
				case (state)
					ST_IDLE:
						timer <= 27'h0000000;
					ST_WAIT:
					begin
						if (answer_valid_i || seq_fail)
						begin
							state <= ST_DONE;
							seq_counter <= seq_counter + SEQ_W'(1);
						end
						timer <= timer - 27'h0000001;
					end
					ST_DONE:
					begin
						// Next sequence rearms with the captured setting
						state <= ST_WAIT;
						timer <= timeout_for(active_config[CFG_SEL_LSB +: CFG_SEL_W]);
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Error counter
	// ----------------------------------------------------------------
	// saturating count
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			error_count <= 3'h0;
		else if (clk_en_i && seq_fail && error_count != ERROR_LIMIT)
			error_count <= error_count + 3'h1;
	end

	// A failure that brings or keeps the count at the limit sets the flag;
	// a level set would make its clear bit useless once the count saturates
	assign limit_hit = seq_fail && (error_count >= ERROR_LIMIT - 3'h1);

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------
	// invalid answer flag
	sticky_flag u_flag_inv (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.set_i(seq_bad),
		.clear_i(answer_invalid_clear),
		.flag_o(flag_inv)
	);

	sticky_flag u_flag_to (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.set_i(seq_timeout),
		.clear_i(answer_timeout_clear),
		.flag_o(flag_to)
	);

	// limit flag; its clear touches nothing else
	sticky_flag u_flag_lim (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.set_i(limit_hit),
		.clear_i(error_count_limit_clear),
		.flag_o(flag_lim)
	);

	assign status = {flag_lim, flag_to, flag_inv};

	// ----------------------------------------------------------------
	// Outputs and read port
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			answer_invalid_flag_o <= 1'b0;
			answer_timeout_flag_o <= 1'b0;
			error_limit_flag_o <= 1'b0;
			irq_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			answer_invalid_flag_o <= flag_inv;
			answer_timeout_flag_o <= flag_to;
			error_limit_flag_o <= flag_lim;
			irq_o <= |(status & mask);
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			reg_rdata_o <= 8'h00;
		else if (clk_en_i)
		begin
			reg_rdata_o <= 8'h00;
			if (reg_read_i)
			begin
				case (reg_addr_i)
					ADDR_CONFIG: reg_rdata_o <= config_reg;
					ADDR_STATUS: reg_rdata_o <= {5'h00, status};
					ADDR_MASK: reg_rdata_o <= {5'h00, mask};
					ADDR_COUNT: reg_rdata_o <= {5'h00, error_count};
					ADDR_ACTIVE: reg_rdata_o <= active_config;
					default: reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_invalid_sets;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(clk_en_i && seq_bad) |=> flag_inv;
	endproperty
	a_invalid_sets: assert property (p_invalid_sets) else $error("invalid flag not set");

	property p_invalid_holds;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(flag_inv && !answer_invalid_clear) |=> flag_inv;
	endproperty
	a_invalid_holds: assert property (p_invalid_holds) else $error("invalid flag dropped");

	property p_timeout_sets;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(clk_en_i && seq_timeout) |=> flag_to ##1 answer_timeout_flag_o;
	endproperty
	a_timeout_sets: assert property (p_timeout_sets) else $error("timeout flag not set");

	property p_limit_sets;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(clk_en_i && limit_hit) |=> flag_lim;
	endproperty
	a_limit_sets: assert property (p_limit_sets) else $error("limit flag not set");

	property p_limit_clear_keeps_seq;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(error_count_limit_clear && !((state == ST_WAIT) && (answer_valid_i || seq_fail)))
			|=> $stable(seq_counter);
	endproperty
	a_limit_clear_keeps_seq: assert property (p_limit_clear_keeps_seq) else $error("seq changed");

	property p_config_latched;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(clk_en_i && start_cmd_i) |=> (active_config == $past(config_reg));
	endproperty
	a_config_latched: assert property (p_config_latched) else $error("config not captured");

	property p_config_held;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		!start_cmd_i |=> $stable(active_config);
	endproperty
	a_config_held: assert property (p_config_held) else $error("config changed mid run");

	property p_count_sat;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		error_count <= ERROR_LIMIT;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("counter past limit");

	property p_count_step;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(clk_en_i && seq_fail && error_count < ERROR_LIMIT)
			|=> error_count == $past(error_count) + 3'h1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step");

endmodule : answer_watchdog_status
`default_nettype wire

//--- sticky_flag.sv
/*
 * One sticky status flag: set by a hardware event, cleared by software.
 * Assumes set and clear are single-cycle pulses in the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
	import answer_watchdog_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// Control
	input wire logic set_i,
	input wire logic clear_i,
	// State
	output logic flag_o
);

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			flag_o <= 1'b0;
		else if (clk_en_i)
		begin
			if (set_i)
				flag_o <= 1'b1;
			else if (clear_i)
				flag_o <= 1'b0;
		end
	end

endmodule : sticky_flag
`default_nettype wire

//--- test_answer_watchdog_status.sv
/*
 * Bench for the answer watchdog status block.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_answer_watchdog_status
	import answer_watchdog_pkg::*;
;
	logic core_clk_i, reset_n_i, go, run, rd_s, wr_s, en;
	logic start, ok_a, bad_a, inv_f, to_f, lim_f, irq;
	logic [7:0] gap, wd, rdata, rv;
	logic [3:0] bad_n, addr;
	int err_count, compares;

	// ----------------------------------------------------------------
	// Parts
	// ----------------------------------------------------------------
	// Short timeout keeps the run brief
	answer_watchdog_status #(.TIMEOUT_CYC(20)) dut_u (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .clk_en_i(en), .start_cmd_i(start),
		.answer_valid_i(ok_a), .answer_bad_i(bad_a), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_write_i(wr_s), .reg_read_i(rd_s),
		.reg_rdata_o(rdata), .answer_invalid_flag_o(inv_f),
		.answer_timeout_flag_o(to_f), .error_limit_flag_o(lim_f), .irq_o(irq));
	watchdog_host_model host_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.go_i(go), .run_i(run), .gap_i(gap), .bad_cnt_i(bad_n),
		.start_cmd_o(start), .answer_valid_o(ok_a), .answer_bad_o(bad_a));

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task give_verdict;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge core_clk_i);
		wr_s <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge core_clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge core_clk_i);
		rd_s <= 1'b0;
		@(negedge core_clk_i);
		rv = rdata;
	endtask : rd

	task host(input logic r, input logic [3:0] b);
		@(posedge core_clk_i);
		run <= r;
		bad_n <= b;
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
	endtask : host

	task wait_flag(input int s, input int lim);
		int n;
		logic [2:0] v;
		n = 0;
		v = {lim_f, to_f, inv_f};
		while (v[s] !== 1'b1)
		begin
			@(negedge core_clk_i);
			v = {lim_f, to_f, inv_f};
			n++;
			if (n > lim)
			begin
				err_count++;
				$display("wrong value at %0t: flag never came", $time);
				give_verdict();
			end
		end
	endtask : wait_flag

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rd(ADDR_CONFIG);
		chk(rv, CONFIG_RESET);
		rd(ADDR_STATUS);
		chk(rv, 8'h00);
		rd(ADDR_MASK);
		chk(rv, {5'h00, MASK_RESET});
		// Clock enable low: the write must not land
		@(posedge core_clk_i);
		en <= 1'b0;
		wr(ADDR_MASK, 8'h05);
		en <= 1'b1;
		rd(ADDR_MASK);
		chk(rv, {5'h00, MASK_RESET});
		wr(4'hF, 8'hFF);
		rd(4'hF);
		chk(rv, 8'h00);
	endtask : t_reset

	task t_invalid;
		wr(ADDR_MASK, 8'h07);
		host(1'b1, 4'h1);
		wait_flag(BIT_INVALID, 40);
		// Good answers follow; the flag must stay
		repeat (20) @(negedge core_clk_i);
		chk({6'h00, inv_f, irq}, 8'h03);
		rd(ADDR_STATUS);
		chk(rv, 8'h01);
		rd(ADDR_COUNT);
		chk(rv, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		repeat (3) @(negedge core_clk_i);
		chk({6'h00, inv_f, irq}, 8'h00);
	endtask : t_invalid

	task t_mask;
		wr(ADDR_MASK, 8'h00);
		host(1'b1, 4'h1);
		wait_flag(BIT_INVALID, 40);
		repeat (3) @(negedge core_clk_i);
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_MASK, 8'h01);
		repeat (3) @(negedge core_clk_i);
		chk({7'h00, irq}, 8'h01);
		rd(ADDR_COUNT);
		chk(rv, 8'h02);
		wr(ADDR_STATUS, 8'h01);
	endtask : t_mask

	task t_timeout;
		wr(ADDR_CONFIG, 8'h01);
		host(1'b0, 4'h0);
		repeat (3) @(posedge core_clk_i);
		// Too late for this sequence
		wr(ADDR_CONFIG, 8'h00);
		rd(ADDR_ACTIVE);
		chk(rv, 8'h01);
		repeat (20) @(negedge core_clk_i);
		chk({7'h00, to_f}, 8'h00);
		wait_flag(BIT_TIMEOUT, 40);
		rd(ADDR_STATUS);
		chk(rv, 8'h02);
		rd(ADDR_COUNT);
		chk(rv, 8'h03);
		wr(ADDR_STATUS, 8'h02);
		repeat (3) @(negedge core_clk_i);
		chk({7'h00, to_f}, 8'h00);
	endtask : t_timeout

	task t_limit;
		wait_flag(BIT_LIMIT, 100);
		rd(ADDR_COUNT);
		chk(rv, 8'h04);
		repeat (100) @(negedge core_clk_i);
		rd(ADDR_COUNT);
		chk(rv, 8'h04);
		// Good answers from here on, so no failure sets the flag again
		host(1'b1, 4'h0);
		wr(ADDR_STATUS, 8'h04);
		repeat (3) @(negedge core_clk_i);
		chk({7'h00, lim_f}, 8'h00);
		rd(ADDR_COUNT);
		chk(rv, 8'h04);
	endtask : t_limit

	initial
	begin
		err_count = 0;
		compares = 0;
		reset_n_i = 1'b0;
		{go, run, rd_s, wr_s} = 4'h0;
		en = 1'b1;
		gap = 8'h05;
		bad_n = 4'h0;
		addr = 4'h0;
		wd = 8'h00;
		repeat (6) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_invalid;
		t_mask;
		t_timeout;
		t_limit;
		give_verdict();
	end
endmodule : test_answer_watchdog_status
`default_nettype wire

//--- watchdog_host_model.sv
/*
 * Host that starts the watchdog and answers it every gap cycles.
 * Assumes one clock shared with the watchdog and an active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module watchdog_host_model
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Control from the bench
	input wire logic go_i,
	input wire logic run_i,
	input wire logic [7:0] gap_i,
	input wire logic [3:0] bad_cnt_i,
	// Towards the watchdog
	output logic start_cmd_o,
	output logic answer_valid_o,
	output logic answer_bad_o
);
	logic [7:0] tick;
	logic [3:0] bad_left;

	// Silent while run is low, so the watchdog times out
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			start_cmd_o <= 1'b0;
			answer_valid_o <= 1'b0;
			answer_bad_o <= 1'b0;
			tick <= 8'h00;
			bad_left <= 4'h0;
		end
		else
		begin
			start_cmd_o <= go_i;
			answer_valid_o <= 1'b0;
			answer_bad_o <= 1'b0;
			if (go_i)
			begin
				tick <= 8'h00;
				bad_left <= bad_cnt_i;
			end
			else if (run_i && tick == gap_i - 8'h01)
			begin
				tick <= 8'h00;
				answer_bad_o <= (bad_left != 4'h0);
				answer_valid_o <= (bad_left == 4'h0);
				if (bad_left != 4'h0)
					bad_left <= bad_left - 4'h1;
			end
			else if (run_i)
				tick <= tick + 8'h01;
		end
	end
endmodule : watchdog_host_model
`default_nettype wire
